// File: inc/pic_pkg.sv
// constants shared by the priority interrupt controller core
// assumes an 8-bit i/o bus with one address line selecting the two ports
package pic_pkg;

  // ****************************************************************
  // port selection
  // ****************************************************************
  localparam logic [7:0] PORT_CMD_ADDR = 8'h20; // command port
  localparam logic [7:0] PORT_DATA_ADDR = 8'h21; // data port
  localparam logic SEL_CMD = PORT_CMD_ADDR[0];
  localparam logic SEL_DATA = PORT_DATA_ADDR[0];

  // ****************************************************************
  // command word fields
  // ****************************************************************
  localparam int W1_NO_WORD4 = 0;
  localparam int W1_SINGLE = 1;
  localparam int W1_LEVEL = 3;
  localparam int CMD_INIT = 4;
  localparam int CMD_OP3 = 3;
  localparam int OP3_POLL = 2;
  localparam int W4_X86 = 0;
  localparam int W4_AEOI = 1;
  localparam int W4_BUF_LO = 2;
  localparam int W4_BUF_HI = 3;
  localparam int W4_SFNM = 4;

  // priority word commands, bits 7..5
  localparam logic [2:0] OP2_AEOI_ROT_CLR = 3'h0;
  localparam logic [2:0] OP2_EOI_NONSPEC = 3'h1;
  localparam logic [2:0] OP2_NOP = 3'h2;
  localparam logic [2:0] OP2_EOI_SPEC = 3'h3;
  localparam logic [2:0] OP2_AEOI_ROT_SET = 3'h4;
  localparam logic [2:0] OP2_ROT_NONSPEC = 3'h5;
  localparam logic [2:0] OP2_SET_PRIO = 3'h6;
  localparam logic [2:0] OP2_ROT_SPEC = 3'h7;

  // read select and special mask codes
  localparam logic [1:0] OP3_RD_REQ = 2'h2;
  localparam logic [1:0] OP3_RD_ISR = 2'h3;
  localparam logic [1:0] OP3_SMM_CLR = 2'h2;
  localparam logic [1:0] OP3_SMM_SET = 2'h3;

  // ****************************************************************
  // reset values and acknowledge sequence
  // ****************************************************************
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] LOWEST_RST = 3'h7;
  localparam logic [2:0] DEFAULT_LEVEL = 3'h7;
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [1:0] ACK_PULSES_X86 = 2'h2;
  localparam logic [1:0] ACK_PULSES_8BIT = 2'h3;
  // synchroniser reset: strobes, chip select and acknowledge idle high
  localparam int SYNC_W = 25;
  localparam logic [SYNC_W-1:0] SYNC_RST = {3'h7, 1'h0, 8'h00, 8'h00, 5'h1F};

  typedef enum logic [1:0] {ST_READY, ST_WORD2, ST_WORD3, ST_WORD4} pic_state_t;

endpackage : pic_pkg

// File: logic/pic_core.sv
// eight-input priority interrupt controller, command and data ports
// assumes bus strobes, requests and cascade lines are asynchronous pins
//
// Notes on behaviour
// R1: command write with bit 4 set starts initialization.
// R2: word one bit 0 clear means word four follows.
// R3: word one bit 1 set is single mode, word three skipped.
// R4: word one bit 3 selects edge (0) or level (1) requests.
// R5: initialization discards pending requests and in-service state.
// R6: command write bits 4,3 clear is priority word; bits 2..0 level.
// R7: code 001 clears top in-service, 011 named level, 010 nothing.
// R8: code 101 rotate on eoi, 100 set auto rotate, 000 clear it.
// R9: code 111 ends level and makes it lowest, 110 only lowest.
// R10: bit 4 clear bit 3 set: 10 reads requests, 11 in-service.
// R11: bit 2 set makes the next read a poll.
// R12: bits 6..5 11 enter special mask, 10 leave it.
// R13: in x86 mode word two bits 7..3 give vector upper bits.
// R14: master word three bits mark lines with slaves attached.
// R15: slave word three bits 2..0 give its identity.
// R16: word four bit 0 selects 8-bit or x86 acknowledge protocol.
// R17: word four bit 1 set ends in-service automatically at ack.
// R18: word four bits 3..2 pick unbuffered, buffered slave, master.
// R19: word four bit 4 enables special fully nested mode.
// R20: data port reads and writes mask; set bit disables line.
// R21: peripheral raises its line and holds it until acknowledged.
// R22: a line that falls before acknowledge yields level 7 vector.
// R23: data writes take word two, three if cascade, four if asked.
`timescale 1ns/1ps
module pic_core (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CS_N,
  input wire logic ADDR0,
  input wire logic IO_READ_STROBE_N,
  input wire logic IO_WRITE_STROBE_N,
  input wire logic [7:0] DIN,
  output logic [7:0] DOUT,
  output logic DOUT_OE,
  input wire logic [7:0] REQUEST_LINES,
  output logic INT,
  input wire logic INTA_N,
  input wire logic [2:0] CAS_IN,
  output logic [2:0] CAS_OUT,
  output logic CAS_OE,
  input wire logic SP_N,
  output logic BUF_EN_N
);
  import pic_pkg::*;
  // ****************************************************************
  // helpers
  // ****************************************************************
  // highest-priority set bit under rotation: {valid, index}
  function automatic logic [3:0] pic_top(input logic [7:0] v,
                                         input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] idx;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      idx = low + 3'(i) + 3'h1;
      if (v[idx]) r = {1'b1, idx};
    end
    return r;
  endfunction : pic_top

  function automatic logic [2:0] pic_rank(input logic [2:0] idx,
                                          input logic [2:0] low);
    return 3'(idx - low - 3'h1);
  endfunction : pic_rank

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] s1_r, s2_r;
  wire [SYNC_W-1:0] s_in = {CS_N, IO_READ_STROBE_N, IO_WRITE_STROBE_N, ADDR0,
                        DIN, REQUEST_LINES, INTA_N, CAS_IN, SP_N};

  // every pin but the clock and reset passes two flops before logic looks at it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end else begin
      s1_r <= s_in;
      s2_r <= s1_r;
    end
  end

  wire cs_n_s = s2_r[24];
  wire rd_n_s = s2_r[23];
  wire wr_n_s = s2_r[22];
  wire a0_s = s2_r[21];
  wire [7:0] din_s = s2_r[20:13];
  wire [7:0] req_s = s2_r[12:5];
  wire inta_n_s = s2_r[4];
  wire [2:0] cas_s = s2_r[3:1];
  wire sp_n_s = s2_r[0];

  // ****************************************************************
  // state
  // ****************************************************************
  pic_state_t st_r;
  logic rd_q_r, wr_q_r, inta_q_r, wcs_r, wa0_r;
  logic [7:0] wdat_r, req_q_r;
  logic ltim_r, single_r, need4_r, x86_r, aeoi_r, sfnm_r, rot_aeoi_r;
  logic [1:0] bufm_r, ack_cnt_r;
  logic [7:0] vbw_r, casc_r, imr_r, isr_r, irr_r, poll_dat_r, dout_r;
  logic [2:0] lowest_r, ack_lvl_r;
  logic smm_r, rsel_isr_r, poll_r, ack_ok_r, ack_me_r, int_r, oe_r;

  // bus strobe edges; write data is held from the last low cycle
  wire wr_ev = wr_n_s & ~wr_q_r & wcs_r;
  wire rd_act = ~rd_n_s & ~cs_n_s;
  wire rd_start = rd_act & rd_q_r;
  wire rd_end = rd_n_s & ~rd_q_r;
  wire inta_start = ~inta_n_s & inta_q_r;
  wire inta_end = inta_n_s & ~inta_q_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_q_r <= 1'b1;
      wr_q_r <= 1'b1;
      inta_q_r <= 1'b1;
      req_q_r <= 8'h00;
      wcs_r <= 1'b0;
      wa0_r <= 1'b0;
      wdat_r <= 8'h00;
    end else begin
      rd_q_r <= rd_n_s;
      wr_q_r <= wr_n_s;
      inta_q_r <= inta_n_s;
      req_q_r <= req_s;
      if (!wr_n_s) begin
        wcs_r <= ~cs_n_s;
        wa0_r <= a0_s;
        wdat_r <= din_s;
      end
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire cmd_wr = wr_ev & (wa0_r == SEL_CMD);
  wire dat_wr = wr_ev & (wa0_r == SEL_DATA);
  wire is_w1 = cmd_wr & wdat_r[CMD_INIT]; // R1
  wire is_op2 = cmd_wr & ~wdat_r[CMD_INIT] & ~wdat_r[CMD_OP3]; // R6
  wire is_op3 = cmd_wr & ~wdat_r[CMD_INIT] & wdat_r[CMD_OP3]; // R10
  wire ready = (st_r == ST_READY);
  wire [2:0] op2 = wdat_r[7:5];
  wire [2:0] lvl = wdat_r[2:0]; // R6

  // ****************************************************************
  // priority resolution
  // ****************************************************************
  // master from buffered mode, else from the strap pin
  wire master = bufm_r[1] ? bufm_r[0] : sp_n_s; // R18
  wire is_slave = ~single_r & ~master;
  wire sel_me = ~is_slave | (cas_s == casc_r[2:0]); // R15
  // special mask mode lets masked in-service levels stop blocking
  wire [7:0] cand = irr_r & ~imr_r & (smm_r ? ~isr_r : 8'hFF); // R20
  wire [7:0] blk = smm_r ? (isr_r & ~imr_r) : isr_r; // R12
  wire [3:0] top_req = pic_top(cand, lowest_r);
  wire [3:0] top_isr = pic_top(blk, lowest_r);
  wire [2:0] rk_req = pic_rank(top_req[2:0], lowest_r);
  wire [2:0] rk_isr = pic_rank(top_isr[2:0], lowest_r);
  // nested slave may interrupt its own level in fully nested mode
  wire same_ok = sfnm_r & master & ~single_r & casc_r[top_req[2:0]]; // R19
  wire req_go = top_req[3] & (~top_isr[3] | (rk_req < rk_isr) |
                ((rk_req == rk_isr) & same_ok));

  // ****************************************************************
  // acknowledge sequence
  // ****************************************************************
  wire [1:0] npulse = x86_r ? ACK_PULSES_X86 : ACK_PULSES_8BIT; // R16
  wire ack_first_end = inta_end & (ack_cnt_r == 2'h1);
  wire ack_last_end = inta_end & (ack_cnt_r == npulse);
  wire ack_set = ack_first_end & ack_ok_r & sel_me;
  wire poll_set = rd_start & poll_r & (a0_s == SEL_CMD) & req_go;
  wire slave_line = master & ~single_r & casc_r[ack_lvl_r]; // R14
  wire resp = ack_me_r & ~slave_line;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_cnt_r <= 2'h0;
      ack_lvl_r <= DEFAULT_LEVEL;
      ack_ok_r <= 1'b0;
      ack_me_r <= 1'b0;
    end else begin
      if (inta_start) ack_cnt_r <= ack_cnt_r + 2'h1;
      else if (ack_last_end) ack_cnt_r <= 2'h0;
      if (inta_start && ack_cnt_r == 2'h0) begin
        ack_ok_r <= req_go;
        ack_lvl_r <= req_go ? top_req[2:0] : DEFAULT_LEVEL; // R22
      end
      if (ack_first_end) ack_me_r <= sel_me;
    end
  end

  // ****************************************************************
  // initialization sequence and configuration
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= ST_READY;
    end else if (is_w1) begin
      st_r <= ST_WORD2; // R1
    end else if (dat_wr) begin
      case (st_r)
        ST_WORD2: st_r <= !single_r ? ST_WORD3 :
                          need4_r ? ST_WORD4 : ST_READY; // R23
        ST_WORD3: st_r <= need4_r ? ST_WORD4 : ST_READY; // R23
        ST_WORD4: st_r <= ST_READY;
        default: st_r <= ST_READY;
      endcase
    end
  end

  // word fields; word four fields not sent keep their defaults from word one, word three keeps its old value
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {ltim_r, single_r, need4_r} <= 3'h0;
      {x86_r, aeoi_r, sfnm_r} <= 3'h0;
      bufm_r <= 2'h0;
      vbw_r <= 8'h00;
      casc_r <= 8'h00;
    end else if (is_w1) begin
      ltim_r <= wdat_r[W1_LEVEL]; // R4
      single_r <= wdat_r[W1_SINGLE]; // R3
      need4_r <= ~wdat_r[W1_NO_WORD4]; // R2
      {x86_r, aeoi_r, sfnm_r} <= 3'h0;
      bufm_r <= 2'h0;
    end else if (dat_wr) begin
      if (st_r == ST_WORD2) vbw_r <= wdat_r; // R13
      if (st_r == ST_WORD3) casc_r <= wdat_r; // R14
      if (st_r == ST_WORD4) begin
        x86_r <= wdat_r[W4_X86]; // R16
        aeoi_r <= wdat_r[W4_AEOI]; // R17
        bufm_r <= wdat_r[W4_BUF_HI:W4_BUF_LO]; // R18
        sfnm_r <= wdat_r[W4_SFNM]; // R19
      end
    end
  end

  // mask register, cleared by initialization
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) imr_r <= MASK_RST;
    else if (is_w1) imr_r <= MASK_RST;
    else if (dat_wr && ready) imr_r <= wdat_r; // R20
  end

  // ****************************************************************
  // operation words
  // ****************************************************************
  wire op2_go = is_op2 & ready;
  wire eoi_top = op2_go & ((op2 == OP2_EOI_NONSPEC) |
                           (op2 == OP2_ROT_NONSPEC)); // R7
  wire eoi_lvl = op2_go & ((op2 == OP2_EOI_SPEC) |
                           (op2 == OP2_ROT_SPEC)); // R9
  wire aeoi_clr = ack_last_end & ack_ok_r & ack_me_r & aeoi_r; // R17
  wire [7:0] isr_clr = ({8{eoi_top & top_isr[3]}} &
                        (8'h01 << top_isr[2:0])) |
                       ({8{eoi_lvl}} & (8'h01 << lvl)) |
                       ({8{aeoi_clr}} & (8'h01 << ack_lvl_r));
  wire [7:0] isr_set = ({8{ack_set}} & (8'h01 << ack_lvl_r)) |
                       ({8{poll_set}} & (8'h01 << top_req[2:0]));

  // set wins over clear in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) isr_r <= 8'h00;
    else if (is_w1) isr_r <= 8'h00; // R5
    else isr_r <= (isr_r & ~isr_clr) | isr_set; // R7
  end

  // rotation: the named or serviced level becomes lowest priority
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lowest_r <= LOWEST_RST;
      rot_aeoi_r <= 1'b0;
    end else if (is_w1) begin
      lowest_r <= LOWEST_RST;
      rot_aeoi_r <= 1'b0;
    end else if (op2_go) begin
      case (op2)
        OP2_AEOI_ROT_SET: rot_aeoi_r <= 1'b1; // R8
        OP2_AEOI_ROT_CLR: rot_aeoi_r <= 1'b0; // R8
        OP2_ROT_NONSPEC: if (top_isr[3]) lowest_r <= top_isr[2:0]; // R8
        OP2_ROT_SPEC, OP2_SET_PRIO: lowest_r <= lvl; // R9
        default: lowest_r <= lowest_r;
      endcase
    end else if (aeoi_clr && rot_aeoi_r) begin
      lowest_r <= ack_lvl_r; // R8
    end
  end

  // read select, poll and special mask
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {smm_r, rsel_isr_r, poll_r} <= 3'h0;
    end else if (is_w1) begin
      {smm_r, rsel_isr_r, poll_r} <= 3'h0;
    end else if (is_op3) begin
      if (wdat_r[1:0] == OP3_RD_REQ) rsel_isr_r <= 1'b0; // R10
      if (wdat_r[1:0] == OP3_RD_ISR) rsel_isr_r <= 1'b1; // R10
      if (wdat_r[6:5] == OP3_SMM_SET) smm_r <= 1'b1; // R12
      if (wdat_r[6:5] == OP3_SMM_CLR) smm_r <= 1'b0; // R12
      poll_r <= wdat_r[OP3_POLL]; // R11
    end else if (rd_end && (a0_s == SEL_CMD)) begin
      poll_r <= 1'b0;
    end
  end

  // ****************************************************************
  // request register
  // ****************************************************************
  // edge mode clears a bit when its line falls, so a dropped request
  // leaves no candidate and the acknowledge returns the default level
  wire [7:0] irr_clr = ({8{ack_set}} & (8'h01 << ack_lvl_r)) |
                       ({8{poll_set}} & (8'h01 << top_req[2:0]));
  wire [7:0] rise = req_s & ~req_q_r;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) irr_r <= 8'h00;
    else if (is_w1) irr_r <= 8'h00; // R5
    else if (ltim_r) irr_r <= req_s; // R4
    else irr_r <= ((irr_r & ~irr_clr) | rise) & req_s; // R22
  end

  // ****************************************************************
  // read data and outputs
  // ****************************************************************
  wire [7:0] vec_x86 = {vbw_r[7:3], ack_lvl_r}; // R13
  wire [7:0] ack_byte = x86_r ? vec_x86 :
                        (ack_cnt_r == 2'h1) ? CALL_OPCODE :
                        (ack_cnt_r == 2'h2) ? {vbw_r[7:5], ack_lvl_r, 2'h0} :
                        vbw_r;
  wire ack_drive = ~inta_n_s & (x86_r ? (ack_cnt_r == 2'h2) & resp :
                   (ack_cnt_r == 2'h1) ? master : resp);
  wire [7:0] rd_byte = (a0_s == SEL_DATA) ? imr_r :
                       poll_r ? poll_dat_r :
                       rsel_isr_r ? isr_r : irr_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      poll_dat_r <= 8'h00;
      dout_r <= 8'h00;
      oe_r <= 1'b0;
      int_r <= 1'b0;
    end else begin
      if (rd_start) poll_dat_r <= {req_go, 4'h0, top_req[2:0]}; // R11
      dout_r <= ~inta_n_s ? ack_byte : rd_byte;
      oe_r <= ack_drive | (rd_act & ~rd_start) | (rd_act & ~poll_r);
      int_r <= req_go & ready;
    end
  end

  assign DOUT = dout_r;
  assign DOUT_OE = oe_r;
  assign INT = int_r;
  // buffer enable follows data drive only in buffered modes
  assign BUF_EN_N = ~(oe_r & bufm_r[1]);
  assign CAS_OUT = ack_lvl_r;
  assign CAS_OE = (ack_cnt_r != 2'h0) & slave_line;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  init_start_a: assert property (is_w1 |=> st_r == ST_WORD2 && // R1
      imr_r == MASK_RST && isr_r == 8'h00)
    else $error("init word one did not restart sequence");
  skip_word4_a: assert property (dat_wr && st_r == ST_WORD3 && // R2
      !need4_r |=> st_r == ST_READY)
    else $error("word four awaited though not requested");
  single_skip_a: assert property (dat_wr && st_r == ST_WORD2 && // R3
      single_r |=> st_r != ST_WORD3)
    else $error("single mode went to word three");
  level_follow_a: assert property (ltim_r && !is_w1 |=> // R4
      irr_r == $past(req_s))
    else $error("level request not following line");
  spec_eoi_a: assert property (eoi_lvl && !isr_set[lvl] |=> // R7
      !isr_r[$past(lvl)])
    else $error("specific end did not clear level");
  set_prio_a: assert property (op2_go && op2 == OP2_SET_PRIO |=> // R9
      lowest_r == $past(lvl))
    else $error("set priority did not move lowest level");
  mask_write_a: assert property (dat_wr && ready && !is_w1 |=> // R20
      imr_r == $past(wdat_r))
    else $error("mask write not stored");
  smm_enter_a: assert property (is_op3 && wdat_r[6:5] == OP3_SMM_SET // R12
      |=> smm_r ##1 smm_r || is_w1 || is_op3)
    else $error("special mask not entered");
  poll_arm_a: assert property (is_op3 && wdat_r[OP3_POLL] |=> // R11
      poll_r)
    else $error("poll not armed");
  default_vec_a: assert property (inta_start && ack_cnt_r == 2'h0 && // R22
      !req_go |=> ack_lvl_r == DEFAULT_LEVEL && !ack_ok_r)
    else $error("missing request did not pick default level");
  auto_end_a: assert property (aeoi_clr && !isr_set[ack_lvl_r] && // R17
      !is_w1 |=> !isr_r[$past(ack_lvl_r)])
    else $error("automatic end left level in service");

endmodule : pic_core

// File: verification/pic_periph_model.sv
// request sources standing at the far side of the interrupt controller
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ps

// ****************************************************************
// peripheral request lines
// ****************************************************************
module pic_periph_model (
  output logic [7:0] request_lines
);
  logic [7:0] line_r = 8'h00;

  // lines go straight to the pins, no pull: idle is driven low
  assign request_lines = line_r;

  // low to high edge, then held high until told otherwise
  task automatic raise(input int n);
    line_r[n] = 1'b1;
  endtask : raise

  // normally called once the acknowledge is over; early only on command
  task automatic drop(input int n);
    line_r[n] = 1'b0;
  endtask : drop
endmodule : pic_periph_model

// File: verification/priority_interrupt_controller_test.sv
// self-checking bench for the priority interrupt controller core
// assumes pic_core and the peripheral model are compiled before it
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end \
end

// ****************************************************************
// bench top
// ****************************************************************
module priority_interrupt_controller_test;
  import pic_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n = 1'b1;
  logic addr0 = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic inta_n = 1'b1;
  logic [7:0] din = 8'h00;
  logic [7:0] dout;
  logic dout_oe;
  logic irq;
  logic buf_en_n;
  logic [7:0] req;
  logic [2:0] cas_in = 3'h0;
  logic sp_n = 1'b1;
  logic [2:0] cas_out;
  logic cas_oe;
  logic [7:0] q8;
  logic [5:0] st6;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  // 25 MHz
  always #20 clk = ~clk;

  pic_periph_model pic_periph_model_i (.request_lines(req));

  pic_core pic_core_i (.CLK(clk), .ARST_N(arst_n), .CS_N(cs_n),
    .ADDR0(addr0), .IO_READ_STROBE_N(rd_n), .IO_WRITE_STROBE_N(wr_n),
    .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe), .REQUEST_LINES(req),
    .INT(irq), .INTA_N(inta_n), .CAS_IN(cas_in), .CAS_OUT(cas_out),
    .CAS_OE(cas_oe), .SP_N(sp_n), .BUF_EN_N(buf_en_n));

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  // strobe low three clocks covers the two-stage synchroniser
  task automatic wr(input logic a, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    addr0 = a;
    din = d;
    wr_n = 1'b0;
    repeat (3) @(negedge clk);
    wr_n = 1'b1;
    cs_n = 1'b1;
    din = ~d;
    repeat (4) @(negedge clk);
  endtask : wr

  // data is sampled five clocks in, past the 3-4 clock answer time
  task automatic rdc(input logic a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    @(negedge clk);
    cs_n = 1'b0;
    addr0 = a;
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("read drive", 1'b1, dout_oe)
    q = dout;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(nm, e, q)
  endtask : rdc

  // one acknowledge pulse; byte and pin state taken mid-pulse
  task automatic pulse(output logic [7:0] q, output logic [5:0] s);
    @(negedge clk);
    inta_n = 1'b0;
    repeat (5) @(negedge clk);
    q = dout;
    s = {dout_oe, buf_en_n, cas_oe, cas_out};
    inta_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : pulse

  // two acknowledge pulses; the vector rides on the second
  task automatic ack(input logic [7:0] e, input string nm);
    logic [7:0] q;
    logic [5:0] s;
    repeat (2) pulse(q, s);
    `CHK(nm, e, q)
    `CHK("vector drive", 1'b1, s[5])
  endtask : ack

  // single controller, edge requests, vector base 08
  task automatic init(input logic [7:0] w4);
    wr(1'b0, 8'h12);
    wr(1'b1, 8'h08);
    wr(1'b1, w4);
  endtask : init

  task automatic intchk(input logic e, input string nm);
    repeat (8) @(negedge clk);
    `CHK(nm, e, irq)
  endtask : intchk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // a hang counts as a mismatch; the whole run needs about 750 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (10) @(negedge clk);
    `CHK("int in reset", 1'b0, irq)
    `CHK("oe in reset", 1'b0, dout_oe)
    `CHK("buffer in reset", 1'b1, buf_en_n)
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    init(8'h01);
    rdc(1'b1, 8'h00, "mask after init");
    wr(1'b1, 8'hA5);
    rdc(1'b1, 8'hA5, "mask readback");
    wr(1'b1, 8'h00);
    // edge request, vector, in-service and end commands
    pic_periph_model_i.raise(3);
    intchk(1'b1, "int on edge");
    wr(1'b0, 8'h0A);
    rdc(1'b0, 8'h08, "request reg");
    ack(8'h0B, "vector three");
    pic_periph_model_i.drop(3);
    wr(1'b0, 8'h0B);
    rdc(1'b0, 8'h08, "in-service reg");
    wr(1'b0, 8'h40);
    rdc(1'b0, 8'h08, "no-op keeps");
    wr(1'b0, 8'h20);
    rdc(1'b0, 8'h00, "plain end");
    // masked line stays quiet until unmasked
    wr(1'b1, 8'h20);
    pic_periph_model_i.raise(5);
    intchk(1'b0, "masked");
    wr(1'b1, 8'h00);
    intchk(1'b1, "unmasked");
    ack(8'h0D, "vector five");
    pic_periph_model_i.drop(5);
    wr(1'b0, 8'h65);
    rdc(1'b0, 8'h00, "named end");
    // poll read stands in for an acknowledge
    pic_periph_model_i.raise(2);
    wr(1'b0, 8'h0C);
    rdc(1'b0, 8'h82, "poll word");
    pic_periph_model_i.drop(2);
    wr(1'b0, 8'h0B);
    rdc(1'b0, 8'h04, "poll in-service");
    wr(1'b0, 8'hA0);
    rdc(1'b0, 8'h00, "rotating end");
    // line dropped before acknowledge gets the default level
    pic_periph_model_i.raise(6);
    intchk(1'b1, "int six");
    pic_periph_model_i.drop(6);
    ack(8'h0F, "default vector");
    wr(1'b0, 8'h20);
    // second setup with automatic end; old mask discarded
    wr(1'b1, 8'hFF);
    init(8'h03);
    rdc(1'b1, 8'h00, "mask discarded");
    wr(1'b0, 8'hC4);
    pic_periph_model_i.raise(3);
    pic_periph_model_i.raise(5);
    intchk(1'b1, "int two lines");
    ack(8'h0D, "five after four lowest");
    pic_periph_model_i.drop(5);
    ack(8'h0B, "then three");
    pic_periph_model_i.drop(3);
    wr(1'b0, 8'h0B);
    rdc(1'b0, 8'h00, "automatic end");
    // cascade master, buffered, 8-bit protocol, slave on line 2
    wr(1'b0, 8'h10);
    wr(1'b1, 8'h28);
    wr(1'b1, 8'h04);
    wr(1'b1, 8'h0C);
    pic_periph_model_i.raise(2);
    intchk(1'b1, "int cascade");
    pulse(q8, st6);
    `CHK("call byte", CALL_OPCODE, q8)
    `CHK("cascade out", 6'h2A, st6)
    pulse(q8, st6);
    `CHK("slave answers", 6'h1A, st6)
    pulse(q8, st6);
    pic_periph_model_i.drop(2);
    wr(1'b0, 8'h20);
    pic_periph_model_i.raise(1);
    intchk(1'b1, "int line one");
    repeat (2) pulse(q8, st6);
    `CHK("byte two", 8'h24, q8)
    `CHK("own answer", 6'h21, st6)
    pulse(q8, st6);
    `CHK("byte three", 8'h28, q8)
    pic_periph_model_i.drop(1);
    // line one in service blocks three until special mask
    pic_periph_model_i.raise(3);
    intchk(1'b0, "nested block");
    wr(1'b1, 8'h02);
    wr(1'b0, 8'h68);
    intchk(1'b1, "special mask");
    wr(1'b0, 8'h48);
    intchk(1'b0, "mask mode left");
    pic_periph_model_i.drop(3);
    // slave three, level requests, word four left out
    sp_n = 1'b0;
    cas_in = 3'h5;
    wr(1'b0, 8'h19);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h03);
    pic_periph_model_i.raise(4);
    intchk(1'b1, "slave int");
    repeat (2) pulse(q8, st6);
    `CHK("other slave", 6'h14, st6)
    pulse(q8, st6);
    cas_in = 3'h3;
    repeat (2) pulse(q8, st6);
    `CHK("own slave", 8'h50, q8)
    `CHK("slave drive", 6'h34, st6)
    pulse(q8, st6);
    `CHK("slave byte three", 8'h40, q8)
    wr(1'b0, 8'h0A);
    rdc(1'b0, 8'h10, "level held");
    wr(1'b0, 8'hE4);
    wr(1'b0, 8'h0B);
    rdc(1'b0, 8'h00, "rotate named end");
    pic_periph_model_i.drop(4);
    close_out();
  end
endmodule : priority_interrupt_controller_test
